// ===== logic/acs_pkg.sv
/*
 file holds: constants, types and encodings for the calibration sequencer.
 assumes: one 100 MHz system clock; master clock taken as that clock.
*/
`default_nettype none
package acs_pkg;
   localparam int ACS_CLK_MHZ = 100;
   localparam logic [1:0] ACS_MODE_NORMAL = 2'h0;
   localparam logic [1:0] ACS_MODE_SELF = 2'h1;
   localparam logic [1:0] ACS_MODE_SYS_ZS = 2'h2;
   localparam logic [1:0] ACS_MODE_SYS_FS = 2'h3;
   localparam logic [3:0] ACS_SELF_MODE_PER = 4'h6;
   localparam logic [3:0] ACS_SELF_RDY_PER = 4'h9;
   localparam logic [3:0] ACS_SYS_MODE_PER = 4'h3;
   localparam logic [3:0] ACS_SYS_RDY_PER = 4'h4;
   localparam logic [3:0] ACS_SELF_ZS_PER = 4'h3;
   localparam logic [3:0] ACS_PER_ONE = 4'h1;
   localparam int ACS_PIPE_MAX_CLK = 2000;
   localparam logic [10:0] ACS_PIPE_MAX = 11'(ACS_PIPE_MAX_CLK);
   localparam logic [23:0] ACS_ONE = 24'h000001;
   localparam logic [15:0] ACS_DATA_RST = 16'h0000;
   // sequencer states, gray along idle-cal-conv-pipe
   typedef enum logic [1:0] {
      ACS_IDLE = 2'b00,
      ACS_CAL = 2'b01,
      ACS_CONV = 2'b11,
      ACS_PIPE = 2'b10
   } acs_state_t;
   typedef struct packed {
      logic op_mode_hi;
      logic op_mode_lo;
   } acs_mode_t;
   typedef struct packed {
      logic update_rate_sel_hi;
      logic update_rate_sel_lo;
   } acs_rate_t;
endpackage
`default_nettype wire

// ===== logic/acs_sequencer.sv
/*
 file holds: calibration sequencer for a sigma-delta converter: mode field,
 output-rate timing, data-ready and the 16-bit result register.
 assumes: host writes mode over a serial port decoded elsewhere (mode_wr_in);
 the modulator/filter supplies results on result_vld_in; periods per rate
 code come in as parameters in system clocks.
*/
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RULE1 - mode 0,1 runs zero then full self cal
// RULE2 - self cal: mode clear 6, ready 9 periods
// RULE3 - mode 1,0 zero-scale system cal, 3/4 periods
// RULE4 - mode 1,1 full-scale system cal, 3/4 periods
// RULE5 - mode bits return 0,0 marking cal done
// RULE6 - one conversion after cal, then ready low
// RULE7 - pipeline delay, at most 2000 master clocks
// RULE8 - host waits for ready, not mode clear
// RULE9 - latest result kept in 16-bit register
// RULE10 - period from rate select; resume normal after
module acs_sequencer
   import acs_pkg::*;
#(
   parameter logic [23:0] PERIOD_0 = 24'h000064,
   parameter logic [23:0] PERIOD_1 = 24'h000050,
   parameter logic [23:0] PERIOD_2 = 24'h000014,
   parameter logic [23:0] PERIOD_3 = 24'h00000A,
   parameter logic [10:0] PIPE_CLK = 11'h3E8
) (
   input wire logic clk_sys_in, // system clock
   input wire logic nrst_in, // async reset, low
   input wire logic mode_wr_in, // pulse: mode field written
   input wire acs_mode_t mode_wdata_in, // mode value written
   input wire acs_rate_t rate_in, // update-rate select
   input wire logic result_vld_in, // pulse: filter result
   input wire logic [15:0] result_in, // filter result word
   output acs_mode_t mode_out, // current mode field
   output logic zero_scale_out, // cal doing zero scale
   output logic calibrating_out, // calibration running
   output logic conversion_ready_n_out, // data ready, low
   output logic [15:0] data_out // data register
);
   acs_state_t state_reg, state_next;
   acs_mode_t mode_reg, mode_next;
   logic [23:0] tick_reg, tick_next;
   logic [3:0] per_reg, per_next;
   logic [10:0] pipe_reg, pipe_next;
   logic rdy_n_reg, rdy_n_next;
   logic zs_reg, zs_next;
   logic [15:0] data_reg, data_next;
   acs_mode_t cal_kind_reg, cal_kind_next;
   logic period_end;

   function automatic logic [23:0] period_of(input acs_rate_t r);
      unique case (r)
         2'b00: period_of = PERIOD_0;
         2'b01: period_of = PERIOD_1;
         2'b10: period_of = PERIOD_2;
         2'b11: period_of = PERIOD_3;
      endcase
   endfunction

   function automatic logic [3:0] mode_per(input acs_mode_t m);
      mode_per = (m == ACS_MODE_SELF) ? ACS_SELF_MODE_PER : ACS_SYS_MODE_PER;
   endfunction

   function automatic logic [3:0] rdy_per(input acs_mode_t m);
      rdy_per = (m == ACS_MODE_SELF) ? ACS_SELF_RDY_PER : ACS_SYS_RDY_PER;
   endfunction

   // output-rate tick from rate select [RULE10]
   assign period_end = (tick_reg + ACS_ONE) >= period_of(rate_in);

   always_comb begin
      state_next = state_reg;
      mode_next = mode_reg;
      tick_next = period_end ? 24'h000000 : tick_reg + ACS_ONE;
      per_next = per_reg;
      pipe_next = pipe_reg;
      rdy_n_next = rdy_n_reg;
      zs_next = zs_reg;
      data_next = data_reg;
      unique case (state_reg)
         ACS_IDLE: begin
            // normal conversions resume while mode is 0,0 [RULE10]
            if (result_vld_in) begin
               data_next = result_in; // [RULE9]
               rdy_n_next = 1'b0;
            end
         end
         ACS_CAL: begin
            if (period_end) begin
               per_next = per_reg + ACS_PER_ONE;
               // self cal: zero scale first, then full scale [RULE1]
               if (mode_reg == ACS_MODE_SELF && per_reg + ACS_PER_ONE == ACS_SELF_ZS_PER) begin
                  zs_next = 1'b0;
               end
               if (per_reg + ACS_PER_ONE == mode_per(mode_reg)) begin
                  mode_next = ACS_MODE_NORMAL; // [RULE2] [RULE3] [RULE4] [RULE5]
                  zs_next = 1'b0;
                  state_next = ACS_CONV;
               end
            end
         end
         ACS_CONV: begin
            // one normal conversion follows the calibration [RULE6]
            if (period_end) begin
               per_next = per_reg + ACS_PER_ONE;
               if (per_reg + ACS_PER_ONE == rdy_per(cal_kind_reg)) begin
                  state_next = ACS_PIPE;
                  pipe_next = 11'h000;
               end
            end
         end
         ACS_PIPE: begin
            pipe_next = pipe_reg + 11'h001;
            // pipeline delay bounded by the ceiling [RULE7]
            if (pipe_reg + 11'h001 >= PIPE_CLK || pipe_reg + 11'h001 >= ACS_PIPE_MAX) begin
               data_next = result_in; // [RULE9]
               rdy_n_next = 1'b0; // [RULE6]
               state_next = ACS_IDLE;
            end
         end
      endcase
      // a calibration write restarts the sequence
      if (mode_wr_in && mode_wdata_in != ACS_MODE_NORMAL) begin
         state_next = ACS_CAL;
         mode_next = mode_wdata_in;
         per_next = 4'h0;
         tick_next = 24'h000000;
         rdy_n_next = 1'b1;
         zs_next = (mode_wdata_in != ACS_MODE_SYS_FS); // [RULE1] [RULE3] [RULE4]
      end
   end

   // calibration kind remembered past the mode clear
   always_comb begin
      cal_kind_next = cal_kind_reg;
      if (mode_wr_in && mode_wdata_in != ACS_MODE_NORMAL) begin
         cal_kind_next = mode_wdata_in;
      end
   end

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_reg <= ACS_IDLE;
         mode_reg <= ACS_MODE_NORMAL;
         cal_kind_reg <= ACS_MODE_NORMAL;
         tick_reg <= 24'h000000;
         per_reg <= 4'h0;
         pipe_reg <= 11'h000;
         rdy_n_reg <= 1'b1;
         zs_reg <= 1'b0;
         data_reg <= ACS_DATA_RST;
      end else begin
         state_reg <= state_next;
         mode_reg <= mode_next;
         cal_kind_reg <= cal_kind_next;
         tick_reg <= tick_next;
         per_reg <= per_next;
         pipe_reg <= pipe_next;
         rdy_n_reg <= rdy_n_next;
         zs_reg <= zs_next;
         data_reg <= data_next;
      end
   end

   assign mode_out = mode_reg;
   assign zero_scale_out = zs_reg;
   assign calibrating_out = (state_reg == ACS_CAL);
   assign conversion_ready_n_out = rdy_n_reg;
   assign data_out = data_reg;

   // ready never drops while calibration is running [RULE8]
   cal_ready_high_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (state_reg == ACS_CAL) |-> conversion_ready_n_out) // [RULE6]
      else $error("ready low during calibration");
   mode_clear_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (state_reg == ACS_CAL && state_next == ACS_CONV && !mode_wr_in) |=> mode_out == 2'h0) // [RULE5]
      else $error("mode not cleared at cal end");
   self_count_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (state_reg == ACS_CAL && $fell(state_reg == ACS_CAL) == 1'b0 && mode_reg == ACS_MODE_SELF)
      |-> per_reg < ACS_SELF_MODE_PER) // [RULE2]
      else $error("self cal overran 6 periods");
   sys_count_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (state_reg == ACS_CAL && mode_reg[1]) |-> per_reg < ACS_SYS_MODE_PER) // [RULE3]
      else $error("system cal overran 3 periods");
   fs_zero_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (state_reg == ACS_CAL && mode_reg == ACS_MODE_SYS_FS) |-> !zero_scale_out) // [RULE4]
      else $error("full-scale cal flagged zero scale");
   self_order_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (state_reg == ACS_CAL && mode_reg == ACS_MODE_SELF) |->
      (zero_scale_out == (per_reg < ACS_SELF_ZS_PER))) // [RULE1]
      else $error("self cal order wrong");
   pipe_bound_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (state_reg == ACS_PIPE) |-> pipe_reg < ACS_PIPE_MAX) // [RULE7]
      else $error("pipeline delay too long");
   data_load_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (state_reg == ACS_IDLE && result_vld_in && !mode_wr_in) |=>
      (data_out == $past(result_in) && !conversion_ready_n_out)) // [RULE9]
      else $error("result not loaded");
   resume_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (state_reg == ACS_IDLE) |-> mode_out == 2'h0) // [RULE10]
      else $error("idle with mode set");
   conv_no_zs_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (state_reg == ACS_CONV) |-> !zero_scale_out) // [RULE1]
      else $error("zero scale flag left after cal");
   conv_ready_high_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (state_reg == ACS_CONV || state_reg == ACS_PIPE) |-> conversion_ready_n_out) // [RULE6]
      else $error("ready low before first conversion");
   conv_mode_clear_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (state_reg == ACS_CONV) |-> mode_out == ACS_MODE_NORMAL) // [RULE5]
      else $error("mode set during conversion");
   pipe_end_load_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (state_reg == ACS_PIPE && state_next == ACS_IDLE && !mode_wr_in) |=>
      (!conversion_ready_n_out && data_out == $past(result_in))) // [RULE7]
      else $error("no result after pipeline delay");
   cal_start_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (mode_wr_in && mode_wdata_in != ACS_MODE_NORMAL) |=>
      (calibrating_out && conversion_ready_n_out &&
      mode_out == $past(mode_wdata_in))) // [RULE2]
      else $error("calibration write not taken");
endmodule // acs_sequencer
`default_nettype wire

// ===== test/acs_filter_model.sv
/*
 file holds: stand-in for the filter side, a new word every 16 clocks.
 assumes: one system clock; pulses only while en_in is high.
*/
`timescale 1ns/1ps
`default_nettype none
module acs_filter_model (
   input wire logic clk_sys_in, // system clock
   input wire logic nrst_in, // async reset, low
   input wire logic en_in, // allow result pulses
   output logic vld_out, // result pulse
   output logic [15:0] word_out // result word
);
   logic [3:0] cnt_reg;
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cnt_reg <= 4'h0;
         vld_out <= 1'b0;
         word_out <= 16'h1234;
      end else begin
         cnt_reg <= cnt_reg + 4'h1;
         vld_out <= en_in && (cnt_reg == 4'hF);
         if (cnt_reg == 4'hF) word_out <= word_out + 16'h1111; // word moves even when idle
      end
   end
endmodule // acs_filter_model
`default_nettype wire

// ===== test/acs_sequencer_bench.sv
/*
 file holds: self-checking bench for the calibration sequencer.
 assumes: periods shortened by parameters; checks in cal_seq sit two clocks
 either side of each expected moment.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; \
   $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module acs_sequencer_bench;
   import acs_pkg::*;
   localparam int P0 = 8;
   localparam int P3 = 12;
   localparam int PIPE = 5;
   logic clk_sys_in = 1'b0;
   logic nrst_in = 1'b0;
   logic mode_wr = 1'b0;
   acs_mode_t wdata = '0;
   acs_rate_t rate = '0;
   logic en = 1'b0;
   logic vld;
   logic [15:0] res;
   acs_mode_t mode_out;
   logic zs, cal, ready_n;
   logic [15:0] data_out;
   int n_errors = 0;
   int tests_run = 0;
   acs_sequencer #(.PERIOD_0(24'h000008), .PERIOD_3(24'h00000C), .PIPE_CLK(11'h005)) dut (
      .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .mode_wr_in(mode_wr),
      .mode_wdata_in(wdata), .rate_in(rate), .result_vld_in(vld), .result_in(res),
      .mode_out(mode_out), .zero_scale_out(zs), .calibrating_out(cal),
      .conversion_ready_n_out(ready_n), .data_out(data_out));
   acs_filter_model fm (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .en_in(en),
      .vld_out(vld), .word_out(res));
   initial begin
      forever #5 clk_sys_in = ~clk_sys_in;
   end
   task automatic skip(int k);
      repeat (k) @(negedge clk_sys_in);
   endtask
   task automatic wr(logic [1:0] m);
      mode_wr = 1'b1;
      wdata = m;
      @(negedge clk_sys_in);
      mode_wr = 1'b0;
   endtask
   // mode held, then 0,0; ready high, then low with the fresh result
   task automatic cal_seq(logic [1:0] m, int nm, int nr);
      logic [15:0] exp_word;
      wr(m);
      skip(nm - 2);
      `CHK(mode_out, acs_mode_t'(m))
      `CHK(cal, 1'b1)
      `CHK(zs, m == ACS_MODE_SYS_ZS)
      skip(4);
      `CHK(mode_out, acs_mode_t'(ACS_MODE_NORMAL))
      skip(nr - nm - 4);
      `CHK(ready_n, 1'b1)
      skip(1);
      // word the design latches at the next rising edge
      exp_word = res;
      skip(3);
      `CHK(ready_n, 1'b0)
      `CHK(data_out, exp_word)
   endtask
   task automatic idle_load();
      `CHK(ready_n, 1'b1)
      `CHK(data_out, ACS_DATA_RST)
      `CHK(mode_out, acs_mode_t'(ACS_MODE_NORMAL))
      en = 1'b1;
      for (int i = 0; i < 40 && vld !== 1'b1; i++) skip(1);
      skip(1);
      en = 1'b0;
      `CHK(data_out, res)
      `CHK(ready_n, 1'b0)
   endtask
   task automatic self_cal();
      rate = 2'h0;
      wr(ACS_MODE_SELF);
      skip(2 * P0 - 2);
      `CHK(zs, 1'b1)
      skip(2 * P0);
      `CHK(zs, 1'b0)
      skip(20);
      cal_seq(ACS_MODE_SELF, 6 * P0, 9 * P0 + PIPE);
   endtask
   task automatic sys_cals();
      rate = 2'h3;
      cal_seq(ACS_MODE_SYS_ZS, 3 * P3, 4 * P3 + PIPE);
      cal_seq(ACS_MODE_SYS_FS, 3 * P3, 4 * P3 + PIPE);
   endtask
   task automatic zero_write_ignored();
      wr(ACS_MODE_SELF);
      skip(3);
      wr(ACS_MODE_NORMAL);
      `CHK(mode_out, acs_mode_t'(ACS_MODE_SELF))
      for (int i = 0; i < 300 && ready_n !== 1'b0; i++) skip(1);
      `CHK(ready_n, 1'b0)
      `CHK(mode_out, acs_mode_t'(ACS_MODE_NORMAL))
   endtask
   // reset in the middle of a calibration, then a clean one
   task automatic reset_mid();
      wr(ACS_MODE_SYS_FS);
      skip(5);
      nrst_in = 1'b0;
      skip(2);
      `CHK(mode_out, acs_mode_t'(ACS_MODE_NORMAL))
      `CHK(cal, 1'b0)
      `CHK(zs, 1'b0)
      `CHK(data_out, ACS_DATA_RST)
      `CHK(ready_n, 1'b1)
      nrst_in = 1'b1;
      skip(1);
      cal_seq(ACS_MODE_SYS_ZS, 3 * P3, 4 * P3 + PIPE);
   endtask
   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #100us;
      n_errors++;
      give_verdict();
   end
   initial begin
      repeat (8) @(negedge clk_sys_in);
      nrst_in = 1'b1;
      skip(1);
      idle_load();
      self_cal();
      sys_cals();
      zero_write_ignored();
      reset_mid();
      give_verdict();
   end
endmodule // acs_sequencer_bench
`default_nettype wire
